// ---- rdec_params.svh ----
`ifndef RDEC_PARAMS_SVH
`define RDEC_PARAMS_SVH

// oscillator periods per instruction cycle
`define RDEC_OSC_PER_CYCLE 3'h4
`define RDEC_PHASE_LAST 2'h3

// instruction word fields
`define RDEC_GRP_HI 13
`define RDEC_GRP_LO 12
`define RDEC_SUB_HI 11
`define RDEC_SUB_LO 8
`define RDEC_DEST_BIT 7
`define RDEC_POS_HI 9
`define RDEC_POS_LO 7
`define RDEC_TGT_HI 10

// group prefixes
`define RDEC_GRP_BYTE 2'h0
`define RDEC_GRP_BIT 2'h1
`define RDEC_GRP_BRANCH 2'h2
`define RDEC_GRP_LIT 2'h3

// fixed control words
`define RDEC_W_STANDBY 14'h0063
`define RDEC_W_KICK 14'h0064
`define RDEC_W_RET 14'h0008
`define RDEC_W_RETIRQ 14'h0009
`define RDEC_W_ZERO_ACC 14'h0103

// file address of the timer register
`define RDEC_TIMER_ADDR 7'h01

// reset values
`define RDEC_ACC_RST 8'h00
`define RDEC_FLAG_RST 1'h0
`define RDEC_TOPD_RST 1'h1

`endif

// ---- rdec_pkg.sv ----
package rdec_pkg;
	typedef enum logic [16:0] {
		RDEC_NONE = 17'h00001,
		RDEC_ADD = 17'h00002,
		RDEC_SUB = 17'h00004,
		RDEC_AND = 17'h00008,
		RDEC_OR = 17'h00010,
		RDEC_XOR = 17'h00020,
		RDEC_DEC = 17'h00040,
		RDEC_INC = 17'h00080,
		RDEC_RLC = 17'h00100,
		RDEC_RRC = 17'h00200,
		RDEC_ZERO = 17'h00400,
		RDEC_PASS = 17'h00800,
		RDEC_INV = 17'h01000,
		RDEC_SWAP = 17'h02000,
		RDEC_BCLR = 17'h04000,
		RDEC_BSET = 17'h08000,
		RDEC_PASSW = 17'h10000
	} rdec_alu_op_t;
endpackage

// ---- rdec_alu.sv ----
module rdec_alu import rdec_pkg::*; (
	// operation and operands
	input wire rdec_alu_op_t op_i,
	input wire logic [7:0] a_i,
	input wire logic [7:0] w_i,
	input wire logic c_i,
	input wire logic [2:0] pos_i,
	// result and flags
	output logic [7:0] res_o,
	output logic c_o,
	output logic dc_o,
	output logic z_o
);
	wire [8:0] add9 = {1'b0, a_i} + {1'b0, w_i};
	wire [4:0] add5 = {1'b0, a_i[3:0]} + {1'b0, w_i[3:0]};
	// subtract: operand minus accumulator, carry means no borrow
	wire [8:0] sub9 = {1'b0, a_i} - {1'b0, w_i};
	wire [4:0] sub5 = {1'b0, a_i[3:0]} - {1'b0, w_i[3:0]};
	wire [7:0] mask = 8'h01 << pos_i;

	always_comb begin
		res_o = a_i;
		c_o = c_i;
		dc_o = 1'b0;
		unique case (op_i)
			RDEC_NONE: res_o = a_i;
			RDEC_ADD: begin
				res_o = add9[7:0];
				c_o = add9[8];
				dc_o = add5[4];
			end
			RDEC_SUB: begin
				res_o = sub9[7:0];
				c_o = ~sub9[8];
				dc_o = ~sub5[4];
			end
			RDEC_AND: res_o = a_i & w_i;
			RDEC_OR: res_o = a_i | w_i;
			RDEC_XOR: res_o = a_i ^ w_i;
			RDEC_DEC: res_o = a_i - 8'h01;
			RDEC_INC: res_o = a_i + 8'h01;
			// nine-bit ring through the carry
			RDEC_RLC: begin
				res_o = {a_i[6:0], c_i};
				c_o = a_i[7];
			end
			RDEC_RRC: begin
				res_o = {c_i, a_i[7:1]};
				c_o = a_i[0];
			end
			RDEC_ZERO: res_o = 8'h00;
			RDEC_PASS: res_o = a_i;
			RDEC_INV: res_o = ~a_i;
			RDEC_SWAP: res_o = {a_i[3:0], a_i[7:4]};
			RDEC_BCLR: res_o = a_i & ~mask;
			RDEC_BSET: res_o = a_i | mask;
			RDEC_PASSW: res_o = w_i;
		endcase
		z_o = (res_o == 8'h00);
	end
endmodule

// ---- rdec_core.sv ----
// How it works
// - add accumulator to register or literal, result to the destination; update carry, nibble carry, zero
// - subtract accumulator from register or literal; update carry, nibble carry, zero
// - AND accumulator with register or literal; only zero flag changes
// - inclusive OR with register or literal; only zero flag changes
// - exclusive OR with register or literal; only zero flag changes
// - decrement sets zero; decrement-skip changes no flag, skips on zero
// - increment sets zero; increment-skip changes no flag, skips on zero
// - rotates go through carry as a nine-bit ring; only carry changes
// - bit group: clear, set, test-skip-clear, test-skip-set on selected bit; no flags
// - literal load, return with literal, plain returns; no flags change
// - branches and true skips take two cycles, second one idles
// - standby and watchdog kick update timeout and sleep flags, one cycle
// - read-modify-write of an I/O port uses pin levels as source
// - writing the timer clears the prescaler when it belongs to the timer
// - destination bit 0 writes accumulator, 1 writes file register 0..7F
// - one instruction cycle equals four clock periods
`include "rdec_params.svh"
module rdec_core import rdec_pkg::*; (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// program memory
	input wire logic [13:0] instr_i,
	output logic fetch_o,
	// file register access
	output logic [6:0] file_addr_o,
	input wire logic [7:0] file_rd_data_i,
	input wire logic file_is_port_i,
	input wire logic [7:0] pin_data_i,
	output logic file_wr_o,
	output logic [7:0] file_wr_data_o,
	// timer prescaler
	input wire logic prescaler_on_timer_i,
	output logic prescaler_clr_o,
	// program flow
	output logic jump_o,
	output logic call_o,
	output logic return_o,
	output logic irq_return_o,
	output logic [10:0] target_o,
	output logic standby_o,
	output logic watchdog_clr_o,
	// core state
	output logic [7:0] acc_o,
	output logic overflow_bit_o,
	output logic nibble_overflow_bit_o,
	output logic null_result_bit_o,
	output logic timeout_flag_o,
	output logic sleep_flag_o
);
	logic rst_a_ff, rst_b_ff;
	logic [7:0] pin_a_ff, pin_b_ff;
	logic [1:0] phase_ff;
	logic [13:0] ir_ff;
	logic ir_vld_ff;
	logic [7:0] acc_ff;
	logic c_ff, dc_ff, z_ff, to_ff, pd_ff;
	// the decoder packs the op code together with its flags, so it is a plain vector here
	logic [16:0] op;
	rdec_alu_op_t alu_op;
	logic use_lit, wr_file, wr_acc, upd_c, upd_dc, upd_z;
	logic skip_zero, test_clr, test_set, is_jump, is_call, is_ret, is_retirq, is_standby, is_kick;
	logic [7:0] res;
	logic alu_c, alu_dc, alu_z;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_a_ff <= 1'b0;
			rst_b_ff <= 1'b0;
		end else begin
			rst_a_ff <= 1'b1;
			rst_b_ff <= rst_a_ff;
		end
	end
	wire rst_n = rst_b_ff;

	// pins are asynchronous to the core clock
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_a_ff <= 8'h00;
			pin_b_ff <= 8'h00;
		end else begin
			pin_a_ff <= pin_data_i;
			pin_b_ff <= pin_a_ff;
		end
	end

	wire cycle_end = (phase_ff == `RDEC_PHASE_LAST);
	wire [1:0] nxt_phase = phase_ff + 2'h1;
	wire exec = cycle_end && ir_vld_ff;
	wire [1:0] grp = ir_ff[`RDEC_GRP_HI:`RDEC_GRP_LO];
	wire [3:0] sub = ir_ff[`RDEC_SUB_HI:`RDEC_SUB_LO];
	wire dest = ir_ff[`RDEC_DEST_BIT];
	wire [2:0] pos = ir_ff[`RDEC_POS_HI:`RDEC_POS_LO];
	// port reads take the pin levels so a read-modify-write cannot copy a stale latch
	wire [7:0] file_val = file_is_port_i ? pin_b_ff : file_rd_data_i;
	wire [7:0] operand = use_lit ? ir_ff[7:0] : file_val;

	// decode; casez wildcards cover every don't-care bit
	always_comb begin
		op = RDEC_NONE;
		{use_lit, wr_file, wr_acc, upd_c, upd_dc, upd_z} = 6'h00;
		{skip_zero, test_clr, test_set, is_jump, is_call} = 5'h00;
		{is_ret, is_retirq, is_standby, is_kick} = 4'h0;
		unique casez (ir_ff)
			14'b00_0000_1???_????: begin
				op = RDEC_PASSW;
				wr_file = 1'b1;
			end
			`RDEC_W_STANDBY: is_standby = 1'b1;
			`RDEC_W_KICK: is_kick = 1'b1;
			`RDEC_W_RET: is_ret = 1'b1;
			`RDEC_W_RETIRQ: is_retirq = 1'b1;
			14'b00_0001_1???_????: begin
				op = RDEC_ZERO;
				wr_file = 1'b1;
				upd_z = 1'b1;
			end
			`RDEC_W_ZERO_ACC: begin
				op = RDEC_ZERO;
				wr_acc = 1'b1;
				upd_z = 1'b1;
			end
			14'b00_001?_????_????, 14'b00_01??_????_????, 14'b00_1???_????_????: begin
				wr_file = dest;
				wr_acc = ~dest;
				unique case (sub)
					4'h7: {op, upd_c, upd_dc, upd_z} = {RDEC_ADD, 3'h7};
					4'h2: {op, upd_c, upd_dc, upd_z} = {RDEC_SUB, 3'h7};
					4'h5: {op, upd_z} = {RDEC_AND, 1'b1};
					4'h4: {op, upd_z} = {RDEC_OR, 1'b1};
					4'h6: {op, upd_z} = {RDEC_XOR, 1'b1};
					4'h3: {op, upd_z} = {RDEC_DEC, 1'b1};
					4'hB: {op, skip_zero} = {RDEC_DEC, 1'b1};
					4'hA: {op, upd_z} = {RDEC_INC, 1'b1};
					4'hF: {op, skip_zero} = {RDEC_INC, 1'b1};
					4'hD: {op, upd_c} = {RDEC_RLC, 1'b1};
					4'hC: {op, upd_c} = {RDEC_RRC, 1'b1};
					4'h8: {op, upd_z} = {RDEC_PASS, 1'b1};
					4'h9: {op, upd_z} = {RDEC_INV, 1'b1};
					4'hE: op = RDEC_SWAP;
					default: {wr_file, wr_acc} = 2'h0;
				endcase
			end
			14'b01_00??_????_????: {op, wr_file} = {RDEC_BCLR, 1'b1};
			14'b01_01??_????_????: {op, wr_file} = {RDEC_BSET, 1'b1};
			14'b01_10??_????_????: test_clr = 1'b1;
			14'b01_11??_????_????: test_set = 1'b1;
			14'b10_0???_????_????: is_call = 1'b1;
			14'b10_1???_????_????: is_jump = 1'b1;
			14'b11_00??_????_????: {op, use_lit, wr_acc} = {RDEC_PASS, 2'h3};
			14'b11_01??_????_????: {op, use_lit, wr_acc, is_ret} = {RDEC_PASS, 3'h7};
			14'b11_111?_????_????: {op, use_lit, wr_acc, upd_c, upd_dc, upd_z} = {RDEC_ADD, 5'h1F};
			14'b11_110?_????_????: {op, use_lit, wr_acc, upd_c, upd_dc, upd_z} = {RDEC_SUB, 5'h1F};
			14'b11_1001_????_????: {op, use_lit, wr_acc, upd_z} = {RDEC_AND, 3'h7};
			14'b11_1000_????_????: {op, use_lit, wr_acc, upd_z} = {RDEC_OR, 3'h7};
			14'b11_1010_????_????: {op, use_lit, wr_acc, upd_z} = {RDEC_XOR, 3'h7};
			default: op = RDEC_NONE;
		endcase
	end

	assign alu_op = rdec_alu_op_t'(op);

	rdec_alu u_rdec_alu (
		.op_i(alu_op),
		.a_i(operand),
		.w_i(acc_ff),
		.c_i(c_ff),
		.pos_i(pos),
		.res_o(res),
		.c_o(alu_c),
		.dc_o(alu_dc),
		.z_o(alu_z)
	);

	wire bit_val = file_val[pos];
	wire skip_hit = (skip_zero && alu_z) || (test_clr && !bit_val) || (test_set && bit_val);
	wire pc_change = is_jump || is_call || is_ret || is_retirq;
	wire flush = exec && (skip_hit || pc_change);
	wire timer_wr = exec && wr_file && (ir_ff[6:0] == `RDEC_TIMER_ADDR);
	wire [7:0] nxt_acc = (exec && wr_acc) ? res : acc_ff;
	wire nxt_c = (exec && upd_c) ? alu_c : c_ff;
	wire nxt_dc = (exec && upd_dc) ? alu_dc : dc_ff;
	wire nxt_z = (exec && upd_z) ? alu_z : z_ff;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			phase_ff <= 2'h0;
			ir_ff <= 14'h0000;
			ir_vld_ff <= 1'b0;
		end else begin
			phase_ff <= nxt_phase;
			if (cycle_end) begin
				ir_ff <= instr_i;
				ir_vld_ff <= !flush;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			acc_ff <= `RDEC_ACC_RST;
			{c_ff, dc_ff, z_ff} <= {3{`RDEC_FLAG_RST}};
			{to_ff, pd_ff} <= {2{`RDEC_TOPD_RST}};
		end else begin
			acc_ff <= nxt_acc;
			{c_ff, dc_ff, z_ff} <= {nxt_c, nxt_dc, nxt_z};
			if (exec && (is_standby || is_kick)) begin
				to_ff <= 1'b1;
				pd_ff <= is_kick;
			end
		end
	end

	// pulses last one clock, from the edge that ends the executing cycle
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			{file_wr_o, prescaler_clr_o, jump_o, call_o} <= 4'h0;
			{return_o, irq_return_o, standby_o, watchdog_clr_o} <= 4'h0;
			file_wr_data_o <= 8'h00;
			target_o <= 11'h000;
		end else begin
			file_wr_o <= exec && wr_file;
			prescaler_clr_o <= timer_wr && prescaler_on_timer_i;
			jump_o <= exec && is_jump;
			call_o <= exec && is_call;
			return_o <= exec && is_ret;
			irq_return_o <= exec && is_retirq;
			standby_o <= exec && is_standby;
			watchdog_clr_o <= exec && is_kick;
			if (exec && wr_file)
				file_wr_data_o <= res;
			if (exec && (is_jump || is_call))
				target_o <= ir_ff[`RDEC_TGT_HI:0];
		end
	end

	assign fetch_o = cycle_end;
	assign file_addr_o = ir_ff[6:0];
	assign acc_o = acc_ff;
	assign overflow_bit_o = c_ff;
	assign nibble_overflow_bit_o = dc_ff;
	assign null_result_bit_o = z_ff;
	assign timeout_flag_o = to_ff;
	assign sleep_flag_o = pd_ff;

	AST_CYCLE_FOUR: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		fetch_o |=> !fetch_o [*3] ##1 fetch_o) else $error("instruction cycle not four clocks");
	AST_BRANCH_IDLE: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(exec && pc_change) |=> (!ir_vld_ff && !exec) [*4]) else $error("branch not followed by idle cycle");
	AST_SKIP_IDLE: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(exec && skip_zero && alu_z) |=> !ir_vld_ff) else $error("zero skip did not discard next word");
	AST_DEST_FILE: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(exec && grp == `RDEC_GRP_BYTE && sub == 4'h7 && dest) |=> file_wr_o && file_wr_data_o == $past(res)
		&& acc_o == $past(acc_ff)) else $error("file destination mishandled");
	AST_ADD_LIT: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(exec && grp == `RDEC_GRP_LIT && ir_ff[11:9] == 3'h7) |=> acc_o == 8'($past(acc_ff) + $past(ir_ff[7:0])))
		else $error("literal add result wrong");
	AST_LOGIC_FLAGS: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(exec && (op == RDEC_AND || op == RDEC_OR || op == RDEC_XOR)) |=> $stable(overflow_bit_o)
		&& $stable(nibble_overflow_bit_o)) else $error("logic op touched carry flags");
	AST_PORT_SRC: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(exec && file_is_port_i && op == RDEC_PASS && !use_lit && dest) |=> file_wr_data_o == $past(pin_b_ff))
		else $error("port write-back not from pins");
	AST_PRESCALER: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(timer_wr && prescaler_on_timer_i) |=> prescaler_clr_o ##1 !prescaler_clr_o)
		else $error("prescaler not cleared on timer write");
	AST_STANDBY: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(exec && is_standby) |=> standby_o && timeout_flag_o && !sleep_flag_o && ir_vld_ff)
		else $error("standby flags or timing wrong");
	AST_BIT_NOFLAG: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(exec && grp == `RDEC_GRP_BIT) |=> $stable(null_result_bit_o) && $stable(overflow_bit_o))
		else $error("bit op changed a flag");
endmodule

// ---- rdec_prog_mem.sv ----
module rdec_prog_mem (
	// clock and fetch strobe
	input wire logic sys_clk_i,
	input wire logic fetch_i,
	// program word
	output logic [13:0] instr_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [13:0] mem_ff [0:15];
	logic [3:0] rd_ff = 4'h0;
	logic [3:0] wr_ff = 4'h0;
	logic [13:0] cur;
	// an empty memory answers with the idle word
	assign cur = (rd_ff != wr_ff) ? mem_ff[rd_ff] : 14'h0000;
	// outside the fetch clock the bus shows garbage, so a late sample cannot pass
	assign instr_o = fetch_i ? cur : ~cur;
	always @(posedge sys_clk_i) begin
		if (fetch_i && rd_ff != wr_ff) begin
			rd_ff <= rd_ff + 4'h1;
		end
	end
	task push(input logic [13:0] w);
		mem_ff[wr_ff] = w;
		wr_ff = wr_ff + 4'h1;
	endtask
endmodule

// ---- rdec_core_test.sv ----
module rdec_core_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [13:0] instr;
	logic fetch, file_wr, pre_clr, jump, call, ret, irq_ret, standby, wd_clr;
	logic file_is_port = 1'b0;
	logic pre_on = 1'b0;
	logic [6:0] file_addr, ea;
	logic [7:0] rd_data = 8'h00;
	logic [7:0] pin = 8'h00;
	logic [7:0] wr_data, acc;
	logic [10:0] target;
	logic c_f, dc_f, z_f, to_f, pd_f;
	int bad_count = 0;
	int cmp_count = 0;
	always #20 sys_clk = ~sys_clk;
	rdec_prog_mem u_rdec_prog_mem (.sys_clk_i(sys_clk), .fetch_i(fetch), .instr_o(instr));
	rdec_core u_rdec_core (
		.sys_clk_i(sys_clk), .rst_n_i(rst_n), .instr_i(instr), .fetch_o(fetch),
		.file_addr_o(file_addr), .file_rd_data_i(rd_data), .file_is_port_i(file_is_port),
		.pin_data_i(pin), .file_wr_o(file_wr), .file_wr_data_o(wr_data),
		.prescaler_on_timer_i(pre_on), .prescaler_clr_o(pre_clr), .jump_o(jump), .call_o(call),
		.return_o(ret), .irq_return_o(irq_ret), .target_o(target), .standby_o(standby),
		.watchdog_clr_o(wd_clr), .acc_o(acc), .overflow_bit_o(c_f), .nibble_overflow_bit_o(dc_f),
		.null_result_bit_o(z_f), .timeout_flag_o(to_f), .sleep_flag_o(pd_f)
	);
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ends just after the next fetch edge; ea is the address shown in that fetch clock
	task step;
		int n;
		n = 0;
		@(negedge sys_clk);
		while (fetch !== 1'b1 && n < 8) begin
			@(negedge sys_clk);
			n++;
		end
		ea = file_addr;
		@(posedge sys_clk);
		#1;
	endtask
	task exec(input logic [13:0] w);
		u_rdec_prog_mem.push(w);
		step;
		step;
	endtask
	task lit(input logic [13:0] w, input logic [7:0] a, input logic [2:0] f);
		exec(w);
		chk({5'h00, c_f, dc_f, z_f, acc}, {5'h00, f, a});
	endtask
	task t_reset;
		int n;
		chk({8'h00, acc}, 16'h0000);
		chk({11'h000, c_f, dc_f, z_f, to_f, pd_f}, 16'h0003);
		step;
		n = 0;
		@(negedge sys_clk);
		while (fetch !== 1'b1 && n < 8) begin
			@(negedge sys_clk);
			n++;
		end
		chk(16'(n), 16'h0003);
		@(posedge sys_clk);
		#1;
		$display("reset test done");
	endtask
	task t_lit;
		lit(14'h3010, 8'h10, 3'h0);
		lit(14'h3E15, 8'h25, 3'h0);
		lit(14'h3FF0, 8'h15, 3'h4);
		lit(14'h3C03, 8'hEE, 3'h0);
		lit(14'h3DFF, 8'h11, 3'h6);
		lit(14'h3900, 8'h00, 3'h7);
		lit(14'h3805, 8'h05, 3'h6);
		lit(14'h3A05, 8'h00, 3'h7);
		lit(14'h33AA, 8'hAA, 3'h7);
		$display("literal test done");
	endtask
	task t_byte;
		logic [3:0] ops [0:11];
		logic [7:0] res [0:11];
		ops = '{4'h7, 4'h2, 4'h5, 4'h4, 4'h6, 4'h3, 4'hA, 4'h9, 4'h8, 4'hE, 4'h1, 4'h0};
		res = '{8'hD9, 8'hAB, 8'h02, 8'hD7, 8'hD5, 8'hC1, 8'hC3, 8'h3D, 8'hC2, 8'h2C, 8'h00, 8'h17};
		exec(14'h3017);
		rd_data = 8'hC2;
		for (int i = 0; i < 12; i++) begin
			exec({2'b00, ops[i], 8'hA5});
			chk({7'h00, file_wr, wr_data}, {8'h01, res[i]});
			chk({1'b0, ea, acc}, 16'h2517);
		end
		exec(14'h0725);
		chk({4'h0, file_wr, c_f, dc_f, z_f, acc}, 16'h00D9);
		rd_data = 8'h01;
		lit(14'h0325, 8'h00, 3'h1);
		rd_data = 8'h05;
		lit(14'h0825, 8'h05, 3'h0);
		rd_data = 8'hFF;
		lit(14'h0A25, 8'h00, 3'h1);
		exec(14'h3000);
		lit(14'h3E00, 8'h00, 3'h1);
		rd_data = 8'h80;
		lit(14'h0D25, 8'h00, 3'h5);
		rd_data = 8'h01;
		lit(14'h0C25, 8'h80, 3'h5);
		lit(14'h3801, 8'h81, 3'h4);
		lit(14'h0103, 8'h00, 3'h5);
		lit(14'h0060, 8'h00, 3'h5);
		$display("byte test done");
	endtask
	// the word after w loads 55; it must vanish when w skips
	task skp(input logic [13:0] w, input logic [7:0] r, input logic [7:0] a);
		rd_data = r;
		u_rdec_prog_mem.push(w);
		u_rdec_prog_mem.push(14'h3055);
		step;
		step;
		step;
		chk({8'h00, acc}, {8'h00, a});
	endtask
	task t_skip;
		skp(14'h0B25, 8'h01, 8'h00);
		skp(14'h0B25, 8'h02, 8'h55);
		skp(14'h0F25, 8'hFF, 8'h00);
		skp(14'h1FA5, 8'h80, 8'h00);
		skp(14'h1BA5, 8'h80, 8'h55);
		exec(14'h3066);
		skp(14'h1BA5, 8'h7F, 8'h66);
		$display("skip test done");
	endtask
	task t_bit;
		rd_data = 8'hFF;
		exec(14'h11A5);
		chk({7'h00, file_wr, wr_data}, 16'h01F7);
		rd_data = 8'h00;
		exec(14'h17A5);
		chk({7'h00, file_wr, wr_data}, 16'h0180);
		$display("bit test done");
	endtask
	task br(input logic [13:0] w, input logic [3:0] p, input logic [10:0] t, input logic [7:0] a);
		u_rdec_prog_mem.push(w);
		u_rdec_prog_mem.push(14'h3077);
		step;
		step;
		chk({1'b0, jump, call, ret, irq_ret, target}, {1'b0, p, t});
		step;
		chk({8'h00, acc}, {8'h00, a});
	endtask
	task t_branch;
		exec(14'h3044);
		br(14'h2ABC, 4'h8, 11'h2BC, 8'h44);
		br(14'h2123, 4'h4, 11'h123, 8'h44);
		br(14'h0008, 4'h2, 11'h123, 8'h44);
		br(14'h0009, 4'h1, 11'h123, 8'h44);
		br(14'h3433, 4'h2, 11'h123, 8'h33);
		$display("branch test done");
	endtask
	task t_ctrl;
		exec(14'h0063);
		chk({12'h000, standby, wd_clr, to_f, pd_f}, 16'h000A);
		exec(14'h0064);
		chk({12'h000, standby, wd_clr, to_f, pd_f}, 16'h0007);
		$display("control test done");
	endtask
	task t_io;
		file_is_port = 1'b1;
		rd_data = 8'hFF;
		pin = 8'h0F;
		exec(14'h08A5);
		chk({7'h00, file_wr, wr_data}, 16'h010F);
		file_is_port = 1'b0;
		$display("port test done");
	endtask
	task t_timer;
		pre_on = 1'b1;
		exec(14'h0081);
		chk(16'(pre_clr), 16'h0001);
		exec(14'h0801);
		chk(16'(pre_clr), 16'h0000);
		pre_on = 1'b0;
		exec(14'h0081);
		chk(16'(pre_clr), 16'h0000);
		$display("timer test done");
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		t_reset;
		t_lit;
		t_byte;
		t_skip;
		t_bit;
		t_branch;
		t_ctrl;
		t_io;
		t_timer;
		test_done;
	end
	// the whole sequence needs well under 1500 clocks; allow 5000
	initial begin
		#200000;
		bad_count++;
		test_done;
	end
endmodule
